// ---- rtl/asr_pkg.sv ----
/*
 Constants for the asynchronous static memory controller: widths,
 pin timing in ns and the derived counts of 40 ns clock cycles.
 Assumes a 25 MHz system clock.
*/
package asr_pkg;
	localparam int ASR_ADDR_W = 15;
	localparam int ASR_DATA_W = 8;
	localparam int ASR_CLK_NS = 40;
	// Fastest grade figures
	localparam int ASR_T_RC_NS = 12;
	localparam int ASR_T_AW_NS = 9;
	localparam int ASR_T_DW_NS = 6;
	localparam int ASR_T_WHZ_NS = 6;
	localparam int ASR_T_WP_NS = 8;
	localparam int ASR_T_OW_NS = 4;
	// Least times round up, at least one cycle; the read count adds one cycle more
	localparam int ASR_RD_CYC = (ASR_T_RC_NS + ASR_CLK_NS - 1) / ASR_CLK_NS + 1;
	localparam int ASR_WP_CYC = ((ASR_T_WHZ_NS + ASR_T_DW_NS > ASR_T_AW_NS ? ASR_T_WHZ_NS + ASR_T_DW_NS
		: ASR_T_AW_NS) + ASR_CLK_NS - 1) / ASR_CLK_NS;
	localparam int ASR_REC_CYC = (ASR_T_OW_NS + ASR_CLK_NS - 1) / ASR_CLK_NS;
	localparam int ASR_CNT_W = 4;
	localparam logic [3:0] ASR_CNT_ZERO = 4'h0;
	typedef enum logic [2:0] {
		ASR_IDLE = 3'b000,
		ASR_READ = 3'b001,
		ASR_WSET = 3'b010,
		ASR_WPULSE = 3'b011,
		ASR_WEND = 3'b100,
		ASR_REC = 3'b101
	} asr_state_e;
endpackage

// ---- rtl/asr_sync.sv ----
/*
 Two flip-flop synchroniser for a bus of pin inputs.
 Assumes a single clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module asr_sync #(
	parameter int W = 8
) (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] sync_reg;
	logic [W-1:0] sync_next;

	always_comb begin
		meta_next = i_async;
		sync_next = meta_reg;
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign o_sync = sync_reg;
endmodule

// ---- rtl/asr_ctrl.sv ----
/*
 Bus master for an asynchronous 32K x 8 static memory. Takes one read or
 write request at a time and drives select, output enable, write enable,
 address and the shared data pins. Assumes the memory pins sit outside the
 clock domain, so read data is synchronised before capture.
*/
`timescale 1ns/1ns
// Overview of operation
// (R01) A write happens only in the overlap of low select and low write enable.
// (R02) With output enable low in a write, the pulse covers float delay plus data setup.
// (R03) With output enable high in a write, the plain minimum pulse suffices.
// (R04) If select falls with or after write enable, the memory keeps its outputs floating.
// (R05) Write enable stays high for the whole of every read.
// (R06) Address is valid no later than the falling edge of select.
// (R07) The master never drives data while the memory may drive it.
// (R08) Read data is valid 12 ns after select and a read lasts at least that long.
// (R09) Read data is valid 6 ns after output enable falls.
// (R10) Old read data holds at least 3 ns after an address change.
// (R11) Address is valid at least 9 ns before the write window ends.
// (R12) Write data is valid at least 6 ns before the write window ends.
// (R13) The memory floats its outputs within 6 ns of write enable falling.
// (R14) The memory does not drive again until 4 ns after a write ends.
// (R15) The memory enters low power within 12 ns of select rising.
// (R16) With select high the memory ignores its strobes and floats its pins.
// (R17) Address stays stable across the whole write window.
module asr_ctrl
	import asr_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic [ASR_ADDR_W-1:0] i_addr,
	input wire logic [ASR_DATA_W-1:0] i_wdata,
	output logic o_busy,
	output logic o_done,
	output logic [ASR_DATA_W-1:0] o_rdata,
	output logic [ASR_ADDR_W-1:0] o_mem_addr,
	output logic o_mem_cs_n,
	output logic o_mem_oe_n,
	output logic o_mem_we_n,
	input wire logic [ASR_DATA_W-1:0] i_mem_dq,
	output logic [ASR_DATA_W-1:0] o_mem_dq,
	output logic o_mem_dq_oe
);
	asr_state_e state_reg, state_next;
	logic [ASR_CNT_W-1:0] cnt_reg, cnt_next;
	logic [ASR_ADDR_W-1:0] addr_reg, addr_next;
	logic [ASR_DATA_W-1:0] wdata_reg, wdata_next;
	logic [ASR_DATA_W-1:0] rdata_reg, rdata_next;
	logic cs_n_reg, cs_n_next;
	logic oe_n_reg, oe_n_next;
	logic we_n_reg, we_n_next;
	logic dq_oe_reg, dq_oe_next;
	logic done_reg, done_next;
	logic [ASR_DATA_W-1:0] dq_sync;

	asr_sync #(
		.W(ASR_DATA_W)
	) u_dq_sync (
		.i_clock(i_clock),
		.i_srst(i_srst),
		.i_async(i_mem_dq),
		.o_sync(dq_sync)
	);

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		rdata_next = rdata_reg;
		cs_n_next = cs_n_reg;
		oe_n_next = oe_n_reg;
		we_n_next = we_n_reg;
		dq_oe_next = dq_oe_reg;
		done_next = 1'b0;
		case (state_reg)
			ASR_IDLE: begin
				cs_n_next = 1'b1;
				oe_n_next = 1'b1;
				we_n_next = 1'b1;
				dq_oe_next = 1'b0;
				if (i_req) begin
					// Address is set with select, never after it
					addr_next = i_addr; // (R06)
					wdata_next = i_wdata;
					cs_n_next = 1'b0;
					if (i_we) begin
						// Output enable stays high; the pulse count still covers float delay plus data setup
						state_next = ASR_WSET; // (R03)
					end else begin
						oe_n_next = 1'b0;
						cnt_next = ASR_CNT_W'(ASR_RD_CYC + 1);
						state_next = ASR_READ; // (R08)
					end
				end
			end
			ASR_READ: begin
				// Write enable held high and data pins released
				we_n_next = 1'b1; // (R05)
				dq_oe_next = 1'b0; // (R07)
				if (cnt_reg == ASR_CNT_ZERO) begin
					rdata_next = dq_sync;
					done_next = 1'b1;
					cs_n_next = 1'b1;
					oe_n_next = 1'b1;
					state_next = ASR_IDLE;
				end else begin
					cnt_next = cnt_reg - 1'b1;
				end
			end
			ASR_WSET: begin
				// Select already low, write enable falls after it
				we_n_next = 1'b0; // (R01)
				dq_oe_next = 1'b1; // (R12)
				cnt_next = ASR_CNT_W'(ASR_WP_CYC - 1); // (R02)
				state_next = ASR_WPULSE;
			end
			ASR_WPULSE: begin
				if (cnt_reg == ASR_CNT_ZERO) begin
					// Address and data held through the window end
					we_n_next = 1'b1; // (R11)
					state_next = ASR_WEND; // (R17)
				end else begin
					cnt_next = cnt_reg - 1'b1;
				end
			end
			ASR_WEND: begin
				cs_n_next = 1'b1;
				dq_oe_next = 1'b0;
				cnt_next = ASR_CNT_W'(ASR_REC_CYC - 1);
				state_next = ASR_REC;
			end
			ASR_REC: begin
				if (cnt_reg == ASR_CNT_ZERO) begin
					done_next = 1'b1;
					state_next = ASR_IDLE;
				end else begin
					cnt_next = cnt_reg - 1'b1;
				end
			end
			default: begin
				state_next = ASR_IDLE;
				cs_n_next = 1'b1;
				oe_n_next = 1'b1;
				we_n_next = 1'b1;
				dq_oe_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			state_reg <= ASR_IDLE;
			cnt_reg <= ASR_CNT_ZERO;
			addr_reg <= '0;
			wdata_reg <= '0;
			rdata_reg <= '0;
			cs_n_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			we_n_reg <= 1'b1;
			dq_oe_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			rdata_reg <= rdata_next;
			cs_n_reg <= cs_n_next;
			oe_n_reg <= oe_n_next;
			we_n_reg <= we_n_next;
			dq_oe_reg <= dq_oe_next;
			done_reg <= done_next;
		end
	end

	logic busy_reg;
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= (state_next != ASR_IDLE);
		end
	end

	assign o_busy = busy_reg;
	assign o_done = done_reg;
	assign o_rdata = rdata_reg;
	assign o_mem_addr = addr_reg;
	assign o_mem_cs_n = cs_n_reg;
	assign o_mem_oe_n = oe_n_reg;
	assign o_mem_we_n = we_n_reg;
	assign o_mem_dq = wdata_reg;
	assign o_mem_dq_oe = dq_oe_reg;

	default clocking @(posedge i_clock); endclocking
	default disable iff (i_srst);

	a_read_we_high: assert property ((!o_mem_oe_n) |-> o_mem_we_n) // (R05)
		else $error("write enable low during read");
	a_no_contention: assert property (!(o_mem_dq_oe && !o_mem_oe_n)) // (R07)
		else $error("data driven while memory may drive");
	a_write_overlap: assert property ($fell(o_mem_we_n) |-> !o_mem_cs_n && !$past(o_mem_cs_n)) // (R01)
		else $error("write enable fell without prior select");
	a_pulse_width: assert property ($fell(o_mem_we_n) |-> !o_mem_we_n [*1] ##1 o_mem_we_n) // (R02)
		else $error("write pulse length wrong");
	a_addr_stable: assert property (!o_mem_cs_n && !$fell(o_mem_cs_n) |-> $stable(o_mem_addr)) // (R17)
		else $error("address moved while selected");
	a_data_setup: assert property ($rose(o_mem_we_n) |-> $past(o_mem_dq_oe) && o_mem_dq_oe) // (R12)
		else $error("write data not held to window end");
	a_read_length: assert property ($fell(o_mem_oe_n) |-> !o_mem_oe_n [*3] ##1 !o_mem_oe_n) // (R08)
		else $error("read shorter than access time");
	a_addr_at_select: assert property ($fell(o_mem_cs_n) |=> $stable(o_mem_addr) [*2]) // (R06)
		else $error("address changed after select fell");
	a_we_after_cs: assert property ($fell(o_mem_we_n) |-> $past(o_mem_cs_n, 1) == 1'b0) // (R04)
		else $error("select fell with write enable");

	c_read: cover property ($fell(o_mem_oe_n) ##[1:10] o_done);
	c_write: cover property ($fell(o_mem_we_n) ##[1:10] o_done);
	c_back_to_back: cover property (o_done ##1 $fell(o_mem_cs_n));
endmodule

// ---- bench/asr_sram_model.sv ----
/*
 Behavioural model of the static memory on the far side of the controller.
 Assumes the controller splits the data pins into in, out and enable.
*/
`timescale 1ns/1ns
module asr_sram_model
	import asr_pkg::*;
(
	input wire logic [ASR_ADDR_W-1:0] i_addr,
	input wire logic i_cs_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic [ASR_DATA_W-1:0] i_dq,
	input wire logic i_dq_oe,
	output logic [ASR_DATA_W-1:0] o_dq,
	output logic o_clash
);
	logic [ASR_DATA_W-1:0] mem [0:(1<<ASR_ADDR_W)-1];
	logic [ASR_DATA_W-1:0] last = 8'h00;
	logic [ASR_DATA_W-1:0] rd;
	wire drv;
	wire standby;
	assign #6 drv = !i_cs_n && !i_oe_n && i_we_n;
	assign #12 rd = mem[i_addr];
	assign #12 standby = i_cs_n;
	// Write lands at the end of the overlap
	always @(posedge i_we_n or posedge i_cs_n) begin
		if (!i_cs_n || !i_we_n) begin
			mem[i_addr] = i_dq;
		end
	end
	always @(i_dq, rd, i_dq_oe, drv) begin
		if (i_dq_oe) begin
			last = i_dq;
		end else if (drv) begin
			last = rd;
		end
	end
	// Released pins show the inverse of the last value
	always @* begin
		if (i_dq_oe) begin
			o_dq = i_dq;
		end else if (drv) begin
			o_dq = rd;
		end else begin
			o_dq = ~last;
		end
	end
	assign o_clash = i_dq_oe && drv;
endmodule

// ---- bench/async_sram_read_write_timing_tb_top.sv ----
/*
 Self-checking bench: controller against the memory model.
 Assumes a 25 MHz clock and synchronous active-high reset.
*/
`timescale 1ns/1ns
module async_sram_read_write_timing_tb_top
	import asr_pkg::*;
;
	logic i_clock = 1'b0;
	logic i_srst = 1'b1;
	logic i_req = 1'b0;
	logic i_we = 1'b0;
	logic [ASR_ADDR_W-1:0] i_addr = 15'h0000;
	logic [ASR_DATA_W-1:0] i_wdata = 8'h00;
	logic o_busy, o_done, o_mem_cs_n, o_mem_oe_n, o_mem_we_n, o_mem_dq_oe, clash, we_q;
	logic [ASR_DATA_W-1:0] o_rdata, o_mem_dq, mem_dq;
	logic [ASR_ADDR_W-1:0] o_mem_addr, addr_q;
	int n_mismatch = 0;
	int check_count = 0;
	asr_ctrl asr_ctrl_i (.i_clock(i_clock), .i_srst(i_srst), .i_req(i_req), .i_we(i_we), .i_addr(i_addr),
		.i_wdata(i_wdata), .o_busy(o_busy), .o_done(o_done), .o_rdata(o_rdata), .o_mem_addr(o_mem_addr),
		.o_mem_cs_n(o_mem_cs_n), .o_mem_oe_n(o_mem_oe_n), .o_mem_we_n(o_mem_we_n), .i_mem_dq(mem_dq),
		.o_mem_dq(o_mem_dq), .o_mem_dq_oe(o_mem_dq_oe));
	asr_sram_model asr_sram_model_i (.i_addr(o_mem_addr), .i_cs_n(o_mem_cs_n), .i_oe_n(o_mem_oe_n),
		.i_we_n(o_mem_we_n), .i_dq(o_mem_dq), .i_dq_oe(o_mem_dq_oe), .o_dq(mem_dq), .o_clash(clash));
	initial begin
		forever #20 i_clock = ~i_clock;
	end
	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Pin watch on every cycle out of reset
	always @(posedge i_clock) begin
		if (i_srst === 1'b0) begin
			if (clash === 1'b1) check(clash, 1'b0);
			if (o_mem_oe_n === 1'b0) check(o_mem_we_n, 1'b1);
			if (o_mem_we_n === 1'b0) check(o_mem_cs_n, 1'b0);
			if (o_mem_we_n === 1'b0) check(o_mem_oe_n, 1'b1);
			if (o_mem_we_n === 1'b0 || we_q === 1'b0) check(o_mem_addr, addr_q);
		end
		we_q <= o_mem_we_n;
		addr_q <= o_mem_addr;
	end
	// One transfer; n_hold edges of ignored request while busy
	task automatic xfer(input logic we, input logic [14:0] a, input logic [7:0] d, input int n_hold);
		int k;
		i_req <= 1'b1;
		i_we <= we;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_addr <= ~a;
		i_wdata <= ~d;
		repeat (n_hold) @(posedge i_clock);
		i_req <= 1'b0;
		k = 0;
		do begin
			@(posedge i_clock);
			k++;
		end while (o_done !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_mismatch++;
			$display("[ERR] %0t no done", $time);
			print_verdict();
		end
	endtask
	task automatic t_idle;
		check({o_mem_cs_n, o_mem_oe_n, o_mem_we_n, o_mem_dq_oe, o_busy}, 5'b11100);
	endtask
	task automatic t_corners;
		logic [14:0] a [4] = '{15'h0000, 15'h7FFF, 15'h0001, 15'h4AB3};
		logic [7:0] d [4] = '{8'hFF, 8'h00, 8'h81, 8'h5E};
		foreach (a[i]) xfer(1'b1, a[i], d[i], 0);
		foreach (a[i]) begin
			xfer(1'b0, a[i], 8'h00, 0);
			check(o_rdata, d[i]);
		end
	endtask
	task automatic t_busy;
		xfer(1'b1, 15'h7EFF, 8'h5A, 0);
		xfer(1'b1, 15'h0100, 8'h3C, 2);
		xfer(1'b0, 15'h7EFF, 8'h00, 0);
		check(o_rdata, 8'h5A);
		xfer(1'b0, 15'h0100, 8'h00, 0);
		check(o_rdata, 8'h3C);
	endtask
	initial begin
		repeat (12) @(posedge i_clock);
		i_srst <= 1'b0;
		@(posedge i_clock);
		t_idle();
		t_corners();
		t_busy();
		t_idle();
		print_verdict();
	end
endmodule
